/* File: verilog/igds_pkg.sv */
// constants and types shared by the isolated gate drive sequencer
package igds_pkg;
  // ==========================================================================
  // clock
  localparam int unsigned CLK_PERIOD_PS   = 20000;
  // ==========================================================================
  // timing (figures as printed)
  localparam int unsigned LONG_OFF_US     = 32;
  localparam int unsigned DISCHARGE_NS    = 20;
  localparam int unsigned NEG_CAP_FF      = 10800;
  // long-off detect: least time, rounded up
  localparam int unsigned LONG_OFF_CYC    = (LONG_OFF_US * 1000000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
  // discharge pulse: least time, rounded up, at least one cycle
  localparam int unsigned DISCHARGE_CYC_R = (DISCHARGE_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
  localparam int unsigned DISCHARGE_CYC   = (DISCHARGE_CYC_R < 1) ? 1 : DISCHARGE_CYC_R;
  // link: pulse spacing during normal state and during long-off
  localparam int unsigned REP_FAST_CYC    = 16;
  localparam int unsigned REP_SLOW_CYC    = 256;
  // receiver watchdog trips when no pulse for this many cycles
  localparam int unsigned WDOG_CYC        = 64;
  localparam int unsigned CNT_W           = 16;
  // ==========================================================================
  // output sequencer states
  typedef enum logic [2:0] {
    IGDS_LONG_OFF,
    IGDS_DISCHARGE,
    IGDS_ON,
    IGDS_NEG_OFF,
    IGDS_ZERO_OFF
  } igds_state_e;
endpackage

/* File: verilog/igds_link_tx.sv */
// input-side transmitter: sends pwm state as repeated pulses over the link
`timescale 1ns/100ps
module igds_link_tx (
  input  wire logic                      sys_clk,
  input  wire logic                      reset,
  input  wire logic                      clkEn,
  input  wire logic                      pwmLevel,
  input  wire logic                      inSupplyOk,
  output logic                           linkPulse,
  output logic                           linkData
);
  import igds_pkg::*;

  logic [igds_pkg::CNT_W-1:0] repCnt_q;
  logic [igds_pkg::CNT_W-1:0] offCnt_q;
  logic                       lastLvl_q;
  logic                       longOff;
  logic                       effLvl;

  assign effLvl  = pwmLevel & inSupplyOk;
  assign longOff = (offCnt_q >= CNT_W'(LONG_OFF_CYC));

  // ==========================================================================
  // off-time measurement
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      offCnt_q <= '0;
    end else if (clkEn) begin
      if (effLvl) begin
        offCnt_q <= '0;
      end else if (!longOff) begin
        offCnt_q <= offCnt_q + 1'b1;
      end
    end
  end

  // ==========================================================================
  // pulse repetition, slowed in long-off so the receiver watchdog trips
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      repCnt_q  <= '0;
      lastLvl_q <= 1'b0;
      linkPulse <= 1'b0;
      linkData  <= 1'b0;
    end else if (clkEn) begin
      lastLvl_q <= effLvl;
      if ((effLvl != lastLvl_q) ||
          (!longOff && repCnt_q >= CNT_W'(REP_FAST_CYC - 1)) ||
          (repCnt_q >= CNT_W'(REP_SLOW_CYC - 1))) begin
        repCnt_q  <= '0;
        linkPulse <= 1'b1;
        linkData  <= effLvl;
      end else begin
        repCnt_q  <= repCnt_q + 1'b1;
        linkPulse <= 1'b0;
      end
    end
  end
endmodule

/* File: verilog/igds_sequencer.sv */
// gate drive sequencer: pwm transmitter, link receiver watchdog, output switches
`timescale 1ns/100ps
module igds_sequencer #(
  parameter int unsigned NEG_OFF_CYC = 10
) (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic clkEn,
  input  wire logic pwmIn,
  input  wire logic inSupplyOk,
  input  wire logic gateSupplyOk,
  input  wire logic sourceSupplyOk,
  output logic      gateSideOutput,
  output logic      sourceSideOutput,
  output logic      zeroLevelPullSwitch,
  output logic      negativeSupplySwitch,
  output logic      linkFault
);
  import igds_pkg::*;

  // elaboration-time check: the negative-off time must fit the timer
  if (NEG_OFF_CYC < 1 || NEG_OFF_CYC >= (1 << CNT_W)) begin : g_chkNegOff
    $error("NEG_OFF_CYC out of range");
  end

  logic [2:0]                 syncA_q;
  logic [2:0]                 syncB_q;
  logic                       pwmS;
  logic                       inOkS;
  logic                       outOkS;
  logic                       linkPulse;
  logic                       linkData;
  logic                       rxLvl_q;
  logic [igds_pkg::CNT_W-1:0] wdogCnt_q;
  logic [igds_pkg::CNT_W-1:0] tmr_q;
  logic                       wdogTrip;
  igds_state_e                state_q;

  // ==========================================================================
  // pin synchronisers; supply good levels come from the analog comparators
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else if (clkEn) begin
      syncA_q <= {pwmIn, inSupplyOk, gateSupplyOk & sourceSupplyOk};
      syncB_q <= syncA_q;
    end
  end
  assign pwmS   = syncB_q[2];
  assign inOkS  = syncB_q[1];
  assign outOkS = syncB_q[0];

  // ==========================================================================
  // input side
  igds_link_tx u_tx (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .clkEn      (clkEn),
    .pwmLevel   (pwmS),
    .inSupplyOk (inOkS),
    .linkPulse  (linkPulse),
    .linkData   (linkData)
  );

  // ==========================================================================
  // receiver with watchdog
  assign wdogTrip = (wdogCnt_q >= CNT_W'(WDOG_CYC));
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wdogCnt_q <= CNT_W'(WDOG_CYC);
      rxLvl_q   <= 1'b0;
    end else if (clkEn) begin
      if (linkPulse) begin
        wdogCnt_q <= '0;
        rxLvl_q   <= linkData;
      end else if (!wdogTrip) begin
        wdogCnt_q <= wdogCnt_q + 1'b1;
      end else begin
        rxLvl_q   <= 1'b0;
      end
    end
  end
  assign linkFault = wdogTrip;

  // ==========================================================================
  // output sequencer
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= IGDS_LONG_OFF;
      tmr_q   <= '0;
    end else if (clkEn) begin
      if (!outOkS || !inOkS) begin
        state_q <= IGDS_LONG_OFF;
        tmr_q   <= '0;
      end else begin
        case (state_q)
          IGDS_LONG_OFF: begin
            if (rxLvl_q && !wdogTrip) begin
              state_q <= IGDS_DISCHARGE;
              tmr_q   <= '0;
            end
          end
          IGDS_DISCHARGE: begin
            tmr_q <= tmr_q + 1'b1;
            if (tmr_q >= CNT_W'(DISCHARGE_CYC - 1)) begin
              state_q <= IGDS_ON;
            end
          end
          IGDS_ON: begin
            if (!rxLvl_q || wdogTrip) begin
              state_q <= IGDS_NEG_OFF;
              tmr_q   <= '0;
            end
          end
          IGDS_NEG_OFF: begin
            tmr_q <= tmr_q + 1'b1;
            if (wdogTrip) begin
              state_q <= IGDS_LONG_OFF;
            end else if (rxLvl_q) begin
              state_q <= IGDS_ON;
            end else if (tmr_q >= CNT_W'(NEG_OFF_CYC - 1)) begin
              state_q <= IGDS_ZERO_OFF;
            end
          end
          IGDS_ZERO_OFF: begin
            if (wdogTrip) begin
              state_q <= IGDS_LONG_OFF;
            end else if (rxLvl_q) begin
              state_q <= IGDS_ON;
            end
          end
          default: begin
            state_q <= IGDS_LONG_OFF;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // switch drive from state
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      gateSideOutput       <= 1'b0;
      sourceSideOutput     <= 1'b1;
      zeroLevelPullSwitch  <= 1'b0;
      negativeSupplySwitch <= 1'b1;
    end else if (clkEn) begin
      gateSideOutput       <= (state_q == IGDS_ON);
      sourceSideOutput     <= (state_q == IGDS_LONG_OFF) || (state_q == IGDS_NEG_OFF);
      zeroLevelPullSwitch  <= (state_q == IGDS_DISCHARGE) || (state_q == IGDS_ZERO_OFF);
      negativeSupplySwitch <= (state_q == IGDS_LONG_OFF);
    end
  end
endmodule

/* File: testbench/igds_sva.sv */
// port checker for the gate drive sequencer
`timescale 1ns/100ps
module igds_sva #(
  parameter int unsigned NEG_OFF_CYC = 10
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic pwmIn,
  input wire logic inSupplyOk,
  input wire logic gateSupplyOk,
  input wire logic sourceSupplyOk,
  input wire logic gateSideOutput,
  input wire logic sourceSideOutput,
  input wire logic zeroLevelPullSwitch,
  input wire logic negativeSupplySwitch,
  input wire logic linkFault
);
  import igds_pkg::*;
  // ==========================================================================
  // helpers
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [CNT_W-1:0] negCnt_q;
  logic [CNT_W-1:0] offCnt_q;
  logic             longOff;
  assign longOff = negativeSupplySwitch && sourceSideOutput && !gateSideOutput
                   && !zeroLevelPullSwitch;
  always_ff @(posedge sys_clk or posedge reset)
    if (reset) negCnt_q <= '0;
    else if (clkEn) negCnt_q <= (sourceSideOutput && !negativeSupplySwitch) ? negCnt_q + 1'b1 : '0;
  always_ff @(posedge sys_clk or posedge reset)
    if (reset) offCnt_q <= '0;
    else if (clkEn) offCnt_q <= (!gateSideOutput && !negativeSupplySwitch) ? offCnt_q + 1'b1 : '0;
  // ==========================================================================
  // assertions
  AST_IN_LOCK: assert property (!inSupplyOk [*5] |-> longOff)
    else $error("input lockout");
  AST_GATE_LOCK: assert property (!gateSupplyOk [*5] |-> longOff)
    else $error("gate lockout");
  AST_SRC_LOCK: assert property (!sourceSupplyOk [*5] |-> longOff)
    else $error("source lockout");
  AST_NEG_STATE: assert property (negativeSupplySwitch |-> longOff)
    else $error("long-off levels");
  AST_ON_STATE: assert property (gateSideOutput |-> !sourceSideOutput && !zeroLevelPullSwitch
    && !negativeSupplySwitch)
    else $error("on levels");
  AST_ON_ENTRY: assert property ($rose(gateSideOutput) |-> $past(zeroLevelPullSwitch)
    && !$past(negativeSupplySwitch))
    else $error("turn-on entry");
  AST_EXIT: assert property ($fell(negativeSupplySwitch) |-> zeroLevelPullSwitch)
    else $error("long-off exit");
  AST_NEG_LEN: assert property ($rose(zeroLevelPullSwitch) && $past(sourceSideOutput)
    && !$past(negativeSupplySwitch) |-> negCnt_q == NEG_OFF_CYC)
    else $error("negative-off length");
  AST_WDOG: assert property ($rose(linkFault) |-> ##[0:4] negativeSupplySwitch)
    else $error("watchdog");
  AST_LONG_MIN: assert property ($rose(negativeSupplySwitch) && $past(inSupplyOk)
    && $past(gateSupplyOk) && $past(sourceSupplyOk) |-> offCnt_q >= LONG_OFF_CYC - 4)
    else $error("long-off early");
  AST_LONG_MAX: assert property (offCnt_q <= LONG_OFF_CYC + REP_SLOW_CYC + WDOG_CYC + 16)
    else $error("long-off late");
  cover property ($fell(negativeSupplySwitch));
  cover property ($rose(zeroLevelPullSwitch) && $past(sourceSideOutput));
  cover property (!inSupplyOk ##1 negativeSupplySwitch);
endmodule

/* File: testbench/igds_pwm_ctrl.sv */
// pwm controller model: one on/off period per go request
`timescale 1ns/100ps
module igds_pwm_ctrl #(
  parameter int unsigned MIN_OFF = 20
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        go,
  input  wire logic [11:0] onLen,
  input  wire logic [11:0] offLen,
  output logic             pwmLevel,
  output logic             busy
);
  logic [12:0] cnt_q;
  logic [11:0] off_q;
  logic [11:0] offEff;
  // off period kept above the negative-off time
  assign offEff = (offLen < 12'(MIN_OFF)) ? 12'(MIN_OFF) : offLen;
  assign busy = (cnt_q != '0);
  assign pwmLevel = (cnt_q > {1'b0, off_q});
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
      off_q <= '0;
    end else if (go && !busy) begin
      cnt_q <= {1'b0, onLen} + {1'b0, offEff};
      off_q <= offEff;
    end else if (busy) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule

/* File: testbench/isolated_gate_drive_sequencer_tb.sv */
// self-checking bench for the gate drive sequencer
`timescale 1ns/100ps
module isolated_gate_drive_sequencer_tb;
  import igds_pkg::*;
  localparam int unsigned NOC = 12;
  localparam logic [3:0] LONGOFF = 4'b0101, ON = 4'b1000, NEGOFF = 4'b0100, ZEROOFF = 4'b0010;
  logic        sys_clk, reset, pwmIn, inSupplyOk, gateSupplyOk, sourceSupplyOk, go, busy, clkEn;
  logic        gateSideOutput, sourceSideOutput, zeroLevelPullSwitch, negativeSupplySwitch;
  logic [11:0] onLen, offLen;
  int          n_errors, total_checks;
  igds_sequencer #(.NEG_OFF_CYC(NOC)) u_dut (.sys_clk, .reset, .clkEn, .pwmIn,
    .inSupplyOk, .gateSupplyOk, .sourceSupplyOk, .gateSideOutput, .sourceSideOutput,
    .zeroLevelPullSwitch, .negativeSupplySwitch, .linkFault());
  igds_pwm_ctrl #(.MIN_OFF(20)) u_ctrl (.sys_clk, .reset, .go, .onLen, .offLen,
    .pwmLevel(pwmIn), .busy);
  function automatic logic [3:0] expOff(input int e);
    return (e < NOC + 8) ? NEGOFF : (e < LONG_OFF_CYC) ? ZEROOFF : LONGOFF;
  endfunction
  task automatic cmpOut(input logic [3:0] exp);
    total_checks++;
    if ({gateSideOutput, sourceSideOutput, zeroLevelPullSwitch, negativeSupplySwitch} !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t outputs differ from %b", $time, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // one pwm period; sel 0..2 drops one supply mid-on
  task automatic period(input int on, input int off, input int sel);
    int k;
    @(posedge sys_clk);
    go <= 1'b1;
    onLen <= 12'(on);
    offLen <= 12'(off);
    @(posedge sys_clk);
    go <= 1'b0;
    if (sel < 3) begin
      repeat (29) @(posedge sys_clk);
      {inSupplyOk, gateSupplyOk, sourceSupplyOk} <= ~(3'b100 >> sel);
      tick(6);
      cmpOut(LONGOFF);
      @(posedge sys_clk);
      {inSupplyOk, gateSupplyOk, sourceSupplyOk} <= 3'b111;
      on = on - 36;
    end
    tick(on - 1);
    cmpOut(ON);
    tick(9);
    cmpOut(expOff(9));
    for (k = 0; k < 3000 && busy; k++) tick(1);
    if (busy) begin
      n_errors++;
      $display("MISMATCH t=%0t pwm period timed out", $time);
      tally_and_finish();
    end
    if (off > NOC + 20) cmpOut(expOff(off));
    $display("period on %0d off %0d sel %0d done", on, off, sel);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    {reset, inSupplyOk, gateSupplyOk, sourceSupplyOk, go} = 5'b1_1110;
    {onLen, offLen} = '0;
    clkEn = 1'b1;
    n_errors = 0;
    total_checks = 0;
    void'($urandom(32'hbd05_fd7e));
    tick(2);
    cmpOut(LONGOFF);
    @(posedge sys_clk);
    reset <= 1'b0;
    period(40, 60, 3);
    for (int s = 0; s < 3; s++) period(80, 60, s);
    period(30, 2100, 3);
    period(40, 60, 3);
    // frozen enable: no long-off may develop while the clock is gated
    @(posedge sys_clk);
    clkEn <= 1'b0;
    tick(2000);
    cmpOut(ZEROOFF);
    @(posedge sys_clk);
    clkEn <= 1'b1;
    $display("clock enable freeze done");
    repeat (6) period(20 + $urandom_range(60), 20 + $urandom_range(200), 3);
    tally_and_finish();
  end
endmodule
bind igds_sequencer igds_sva #(.NEG_OFF_CYC(NEG_OFF_CYC)) u_sva (.sys_clk, .reset, .clkEn,
  .pwmIn, .inSupplyOk, .gateSupplyOk, .sourceSupplyOk, .gateSideOutput, .sourceSideOutput,
  .zeroLevelPullSwitch, .negativeSupplySwitch, .linkFault);
